// file: logic/frs_defs.vh
// constants for the fan ramp smoothing control block
// Summary of operation
// - remote1 duty ramps gradually toward its target
// - fast table sweeps 37.5 down to 0.8 s
// - slow selector gives 52.2 down to 1.1 s
// - slow-down bit 0 quarters the remote1 rate; bits 1-2 are unused
// - smoothing applies only when enable bit set
// - sync bit set: speed inputs 2-4 follow drive3
// - sync bit clear: only inputs 3-4 follow drive3
// - drive1 below floor: 0% or minimum by bit5
// - drive2 below floor: 0% or minimum by bit6
// - drive3 below floor: 0% or minimum by bit7
// - global lock makes the register read-only
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH
`define FRS_ADDR_ACOU1 12'h062
`define FRS_ADDR_CFG6 12'h010
`define FRS_ADDR_CFG1 12'h040
`define FRS_ADDR_TARGET 12'h100
`define FRS_ADDR_MIN 12'h104
`define FRS_ADDR_STATUS 12'h108
`define FRS_ACOU1_RESET 8'h00
`define FRS_CFG6_RESET 8'h00
`define FRS_MIN_RESET 8'h00
`define FRS_BIT_SMOOTH_EN 3
`define FRS_BIT_SYNC 4
`define FRS_BIT_FLOOR1 5
`define FRS_BIT_FLOOR2 6
`define FRS_BIT_FLOOR3 7
`define FRS_BIT_SLOW 7
`define FRS_BIT_LOCK 1
// slot: 37.5 s / (255 steps * 240 slots) for the slowest code; 52.2 s slow
`define FRS_SLOT_FAST_NS 612745
`define FRS_SLOT_SLOW_NS 852941
`define FRS_CLK_MHZ 250
`define FRS_SLOWDOWN_FACTOR 4
`endif

// file: logic/frs_slot_timer.v
// time slot enable generator for the duty ramp
`timescale 1ns/1ps
module frs_slot_timer #(
   parameter integer SLOT_FAST_CYC = 153186,
   parameter integer SLOT_SLOW_CYC = 213235
) (
   input wire pclk,
   input wire presetn,
   input wire slow_sel,
   output reg slot_tick
);
   reg [31:0] cnt_q;
   wire [31:0] limit;
   // slow selector stretches the slot period
   assign limit = slow_sel ? SLOT_SLOW_CYC[31:0] : SLOT_FAST_CYC[31:0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h0;
         slot_tick <= 1'b0;
      end else if (cnt_q + 32'h1 >= limit) begin
         cnt_q <= 32'h0;
         slot_tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         slot_tick <= 1'b0;
      end
   end
endmodule

// file: logic/frs_top.v
// remote1 ramp smoothing, floor select and speed sync with apb registers
`timescale 1ns/1ps
`include "frs_defs.vh"
module frs_top #(
   parameter integer SLOT_FAST_CYC =
      `FRS_SLOT_FAST_NS * `FRS_CLK_MHZ / 1000,
   parameter integer SLOT_SLOW_CYC =
      `FRS_SLOT_SLOW_NS * `FRS_CLK_MHZ / 1000
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire auto_mode,
   input wire [2:0] below_floor,
   input wire [7:0] remote1_target_duty,
   input wire [7:0] drive2_duty_in,
   input wire [7:0] drive3_duty_in,
   input wire [2:0] channel_slowdown,
   output reg [7:0] fan_drive_output_1,
   output reg [7:0] fan_drive_output_2,
   output reg [7:0] fan_drive_output_3,
   output reg [2:0] speed_sync_to_drive3
);
   reg [7:0] acou1_q;
   reg [7:0] cfg6_q;
   reg lock_q;
   reg [7:0] floor1_q;
   reg [7:0] floor2_q;
   reg [7:0] floor3_q;
   reg [7:0] duty1_q;
   reg [7:0] slot_cnt_q;
   reg [1:0] quarter_q;
   wire slot_tick;
   wire wr_en;
   wire [2:0] ramp_rate;
   wire smooth_en;
   wire [7:0] min_reg_rd;

   // slots per step: higher codes ramp faster, sweep time scales with count
   function [7:0] slots_per_step;
      input [2:0] code;
      begin
         case (code)
            3'h0: slots_per_step = 8'hf0;
            3'h1: slots_per_step = 8'h78;
            3'h2: slots_per_step = 8'h50;
            3'h3: slots_per_step = 8'h30;
            3'h4: slots_per_step = 8'h1e;
            3'h5: slots_per_step = 8'h14;
            3'h6: slots_per_step = 8'h0a;
            default: slots_per_step = 8'h05;
         endcase
      end
   endfunction

   // floor duty: minimum when selected else off
   function [7:0] floor_duty;
      input sel;
      input [7:0] minimum;
      begin
         floor_duty = sel ? minimum : 8'h00;
      end
   endfunction

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel & penable & pwrite;
   assign ramp_rate = acou1_q[2:0];
   assign smooth_en = acou1_q[`FRS_BIT_SMOOTH_EN];
   assign min_reg_rd = floor1_q;

   frs_slot_timer #(
      .SLOT_FAST_CYC(SLOT_FAST_CYC),
      .SLOT_SLOW_CYC(SLOT_SLOW_CYC)
   ) u_slot (
      .pclk(pclk),
      .presetn(presetn),
      .slow_sel(cfg6_q[`FRS_BIT_SLOW]),
      .slot_tick(slot_tick)
   );

   // register writes; lock is sticky until reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acou1_q <= `FRS_ACOU1_RESET;
         cfg6_q <= `FRS_CFG6_RESET;
         lock_q <= 1'b0;
         floor1_q <= `FRS_MIN_RESET;
         floor2_q <= `FRS_MIN_RESET;
         floor3_q <= `FRS_MIN_RESET;
      end else if (wr_en) begin
         case (paddr)
            `FRS_ADDR_ACOU1: begin
               if (!lock_q)
                  acou1_q <= pwdata[7:0];
            end
            `FRS_ADDR_CFG6: begin
               cfg6_q <= pwdata[7:0];
            end
            `FRS_ADDR_CFG1: begin
               if (pwdata[`FRS_BIT_LOCK])
                  lock_q <= 1'b1;
            end
            `FRS_ADDR_MIN: begin
               floor1_q <= pwdata[7:0];
               floor2_q <= pwdata[15:8];
               floor3_q <= pwdata[23:16];
            end
            default: begin
               lock_q <= lock_q;
            end
         endcase
      end
   end

   always @* begin
      case (paddr)
         `FRS_ADDR_ACOU1: prdata = {24'h0, acou1_q};
         `FRS_ADDR_CFG6: prdata = {24'h0, cfg6_q};
         `FRS_ADDR_CFG1: prdata = {30'h0, lock_q, 1'b0};
         `FRS_ADDR_TARGET: prdata = {24'h0, remote1_target_duty};
         `FRS_ADDR_MIN: prdata = {8'h0, floor3_q, floor2_q, min_reg_rd};
         `FRS_ADDR_STATUS: prdata = {21'h0, speed_sync_to_drive3,
                                    duty1_q};
         default: prdata = 32'h0;
      endcase
   end

   // remote1 ramp engine: one duty step per slot count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty1_q <= 8'h00;
         slot_cnt_q <= 8'h00;
         quarter_q <= 2'h0;
      end else if (!smooth_en) begin
         duty1_q <= remote1_target_duty;
         slot_cnt_q <= 8'h00;
         quarter_q <= 2'h0;
      end else if (duty1_q == remote1_target_duty) begin
         slot_cnt_q <= 8'h00;
         quarter_q <= 2'h0;
      end else if (slot_tick) begin
         if (slot_cnt_q + 8'h01 >= slots_per_step(ramp_rate)) begin
            slot_cnt_q <= 8'h00;
            // slowdown bit: need four full step periods per step
            if (channel_slowdown[0] && quarter_q != 2'h3) begin
               quarter_q <= quarter_q + 2'h1;
            end else begin
               quarter_q <= 2'h0;
               if (duty1_q < remote1_target_duty)
                  duty1_q <= duty1_q + 8'h01;
               else
                  duty1_q <= duty1_q - 8'h01;
            end
         end else begin
            slot_cnt_q <= slot_cnt_q + 8'h01;
         end
      end
   end

   // outputs with floor handling in automatic mode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_drive_output_1 <= 8'h00;
         fan_drive_output_2 <= 8'h00;
         fan_drive_output_3 <= 8'h00;
         speed_sync_to_drive3 <= 3'h0;
      end else begin
         if (auto_mode && below_floor[0])
            fan_drive_output_1 <= floor_duty(acou1_q[`FRS_BIT_FLOOR1],
                                             floor1_q);
         else
            fan_drive_output_1 <= duty1_q;
         if (auto_mode && below_floor[1])
            fan_drive_output_2 <= floor_duty(acou1_q[`FRS_BIT_FLOOR2],
                                             floor2_q);
         else
            fan_drive_output_2 <= drive2_duty_in;
         if (auto_mode && below_floor[2])
            fan_drive_output_3 <= floor_duty(acou1_q[`FRS_BIT_FLOOR3],
                                             floor3_q);
         else
            fan_drive_output_3 <= drive3_duty_in;
         // bit0 = input2, bit1 = input3, bit2 = input4
         if (acou1_q[`FRS_BIT_SYNC])
            speed_sync_to_drive3 <= 3'h7;
         else
            speed_sync_to_drive3 <= 3'h6;
      end
   end
endmodule

// file: verification/frs_fan_model.sv
// behavioural fans hanging on the three drive outputs
`timescale 1ns/1ps
module frs_fan_model (
   input wire pclk,
   input wire [7:0] drive1,
   input wire [7:0] drive2,
   input wire [7:0] drive3,
   output reg [2:0] spin_q
);
   // a fan at 0% duty stands still, any other code keeps it turning
   always @(posedge pclk) begin
      spin_q <= {drive3 != 8'h00, drive2 != 8'h00, drive1 != 8'h00};
   end
endmodule

// file: verification/frs_top_assertions.sv
// port level checker for the fan ramp smoothing block
`timescale 1ns/1ps
module frs_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire auto_mode,
   input wire [2:0] below_floor,
   input wire [7:0] remote1_target_duty,
   input wire [7:0] fan_drive_output_1,
   input wire [7:0] fan_drive_output_2,
   input wire [7:0] fan_drive_output_3,
   input wire [2:0] speed_sync_to_drive3
);
   reg [7:0] rr_q;
   reg lk_q;
   reg [23:0] mn_q;
   wire wr = psel & penable & pwrite;
   // shadow of the ramp register, lock and minimums seen on the bus
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rr_q <= 8'h00;
         lk_q <= 1'b0;
         mn_q <= 24'h000000;
      end else if (wr) begin
         if (paddr == 12'h062 && !lk_q) rr_q <= pwdata[7:0];
         if (paddr == 12'h040) lk_q <= lk_q | pwdata[1];
         if (paddr == 12'h104) mn_q <= pwdata[23:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sync_map_a: assert property ($past(presetn) |->
      speed_sync_to_drive3 == {2'b11, $past(rr_q[4])}) else $error("sync");
   floor_one_a: assert property (auto_mode && below_floor[0] |=>
      fan_drive_output_1 == ($past(rr_q[5]) ? $past(mn_q[7:0]) : 8'h00))
      else $error("floor 1");
   floor_two_a: assert property (auto_mode && below_floor[1] |=>
      fan_drive_output_2 == ($past(rr_q[6]) ? $past(mn_q[15:8]) : 8'h00))
      else $error("floor 2");
   floor_three_a: assert property (auto_mode && below_floor[2] |=>
      fan_drive_output_3 == ($past(rr_q[7]) ? $past(mn_q[23:16]) : 8'h00))
      else $error("floor 3");
   lock_readback_a: assert property (psel && penable && !pwrite &&
      paddr == 12'h062 |-> prdata[7:0] == rr_q) else $error("readback");
   ramp_unit_a: assert property (rr_q[3] && !auto_mode &&
      $past(rr_q[3]) && $past(rr_q[3], 2) && !$past(auto_mode) |->
      (fan_drive_output_1 - $past(fan_drive_output_1)) inside
      {8'h00, 8'h01, 8'hff}) else $error("ramp jump");
   // a slot is never shorter than four cycles, so steps stand apart
   step_gap_a: assert property ($changed(fan_drive_output_1) &&
      rr_q[3] && $past(rr_q[3], 2) && !auto_mode |=>
      $stable(fan_drive_output_1) [*3]) else $error("step gap");
   smooth_off_a: assert property (!rr_q[3] && !auto_mode ##1
      !rr_q[3] && !auto_mode |=>
      fan_drive_output_1 == $past(remote1_target_duty, 2))
      else $error("follow");
   cover property (rr_q[3] && $changed(fan_drive_output_1));
   cover property (auto_mode && below_floor[0] && rr_q[5]);
   cover property (lk_q && wr && paddr == 12'h062);
endmodule
bind frs_top frs_chk u_chk (.*);

// file: verification/frs_top_tb_top.sv
// testbench for the fan ramp smoothing block
`timescale 1ns/1ps
module frs_top_tb_top;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, r;
   reg auto_mode = 0;
   reg [2:0] below_floor = 0, slowdn = 0;
   reg [7:0] tgt = 0, d2 = 8'h5a, d3 = 8'ha5;
   wire pready, pslverr;
   wire [31:0] prdata;
   wire [7:0] o1, o2, o3;
   wire [2:0] sy, spin;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n, p, c;
   int sps[8] = '{240, 120, 80, 48, 30, 20, 10, 5};
   always #2 pclk = ~pclk;
   frs_top #(.SLOT_FAST_CYC(4), .SLOT_SLOW_CYC(6)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .auto_mode(auto_mode), .below_floor(below_floor),
      .remote1_target_duty(tgt), .drive2_duty_in(d2), .drive3_duty_in(d3),
      .channel_slowdown(slowdn), .fan_drive_output_1(o1),
      .fan_drive_output_2(o2), .fan_drive_output_3(o3),
      .speed_sync_to_drive3(sy));
   frs_fan_model fans (.pclk(pclk), .drive1(o1), .drive2(o2), .drive3(o3),
      .spin_q(spin));
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   // setup, then access held until pready is seen high at an edge
   task xfer(input w, input [11:0] a, input [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         stop_test;
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      repeat (2) @(posedge pclk);
      xfer(0, 12'h062, 0);
      chk(r[7:0], 8'h00);
      xfer(0, 12'h108, 0);
      chk(r[10:8], 3'h6);
      xfer(1, 12'h062, 32'h10);
      xfer(0, 12'h108, 0);
      chk(r[10:8], 3'h7);
      xfer(0, 12'hffc, 0);
      chk(r, 0);
      $display("register test done");
      // eight codes fast, then slow selector and per-channel slow-down
      for (int i = 0; i < 10; i++) begin
         c = (i < 8) ? i : (i - 8) * 2;
         p = sps[c] * (i == 8 ? 6 : 4) * (i == 9 ? 4 : 1);
         xfer(1, 12'h010, i == 8 ? 32'h80 : 32'h00);
         slowdn <= (i == 9) ? 3'h1 : 3'h0;
         xfer(1, 12'h062, 0);
         tgt <= 8'h00;
         repeat (4) @(posedge pclk);
         xfer(1, 12'h062, 32'h08 | c);
         tgt <= 8'h02;
         n = 0;
         while (o1 !== 8'h02 && n < 6000) begin
            @(posedge pclk);
            n++;
         end
         chk(n > p && n <= 2 * p + 6, 1);
      end
      $display("ramp test done");
      xfer(1, 12'h104, 32'h302010);
      auto_mode <= 1;
      below_floor <= 3'h7;
      xfer(1, 12'h062, 32'he0);
      repeat (3) @(posedge pclk);
      chk({o3, o2, o1}, 24'h302010);
      xfer(1, 12'h062, 0);
      repeat (3) @(posedge pclk);
      chk({o3, o2, o1, 5'h0, spin}, 0);
      below_floor <= 3'h0;
      repeat (3) @(posedge pclk);
      chk({o3, o2}, {d3, d2});
      auto_mode <= 0;
      $display("floor test done");
      xfer(1, 12'h062, 32'h1c);
      xfer(1, 12'h040, 32'h2);
      xfer(1, 12'h062, 32'h55);
      xfer(0, 12'h062, 0);
      chk(r[7:0], 8'h1c);
      $display("lock test done");
      stop_test;
   end
endmodule
